// ===== cij_exec_core.sv
// execution core for idle, increment, interrupt return, jumps and loads
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns

// What this block does
// - idle opcode stops the cpu clock enable and the divider; the system clock keeps running
// - while idle, an interrupt request restarts execution; reset ends idle and leaves the core stopped
// - increment adds one to an 8-bit operand, writes it back, keeps carry
// - increment sets zero on zero result and sign on negative result
// - increment sets overflow only for 7f to 80, clears it otherwise
// - interrupt return pops flags then program counter from the stack
// - interrupt return re-enables interrupts; flags return to pre-interrupt values
// - conditional absolute jump loads the target only when the condition holds
// - unconditional absolute jump loads the pc from a register pair
// - register pair target: high byte lower address, low byte next address
// - three-byte absolute jump is conditional, two-byte is unconditional
// - conditional jump first byte: condition nibble high, opcode nibble low
// - relative jump adds displacement when condition holds, else falls through
// - relative displacement is signed 8 bits, +127 to -128
// - displacement is added to the address after the two-byte jump
// - relative jump is two bytes, six cycles, condition high, opcode b low
// - loads copy source to destination, leave source and flags alone
module cij_exec_core import cij_pkg::*; #(
  parameter int PROG_DEPTH = 256,
  parameter int CPU_DIV    = 1
) (
  // clock and reset
  input  logic        clk_sys,
  input  logic        rst,
  // avalon-mm slave
  input  logic [5:0]  avs_address,
  input  logic        avs_read,
  input  logic        avs_write,
  input  logic [31:0] avs_writedata,
  input  logic [3:0]  avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic        avs_waitrequest,
  // core pins
  input  logic        irq,
  output logic        cpuIdle,
  output logic        cpuHalted
);

  localparam int         PAW      = $clog2(PROG_DEPTH);
  localparam logic [7:0] DIV_LAST = 8'(CPU_DIV - 1);

  if (PROG_DEPTH < 16 || PROG_DEPTH > 65536 ||
      (PROG_DEPTH & (PROG_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("PROG_DEPTH must be a power of two from 16 to 65536");
  end
  if (CPU_DIV < 1 || CPU_DIV > 256) begin : g_bad_div
    $error("CPU_DIV must be from 1 to 256");
  end

  typedef struct packed {
    logic [PROG_DEPTH-1:0][7:0] prog;
    logic [255:0][7:0]          regs;
    cij_state_e                 st;
    logic [15:0]                pc;
    logic [15:0]                ivec;
    logic [15:0]                paddr;
    logic [7:0]                 raddr;
    logic [7:0]                 sp;
    logic [7:0]                 flags;
    logic                       run;
    logic                       ie;
    logic                       halted;
    logic                       idle;
    logic [3:0]                 waitCnt;
    logic [7:0]                 divCnt;
    logic                       tick;
    logic [1:0]                 irqSync;
    logic                       waitReq;
    logic [31:0]                rdata;
  } cij_core_s;

  cij_core_s q_r;
  cij_core_s q_nxt;

  cij_exec_if ex();

  cij_inc_unit u_inc (
    .ex (ex)
  );

  cij_branch_unit u_br (
    .ex (ex)
  );

  function automatic logic [7:0] workAddr(input logic [3:0] n);
    return {WORK_BASE[7:4], n};
  endfunction : workAddr

  // register addresses ex..ef name working registers
  function automatic logic [7:0] resolve(input logic [7:0] a);
    return (a[7:4] == NIB_WORK) ? {WORK_BASE[7:4], a[3:0]} : a;
  endfunction : resolve

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  logic [15:0] pc1;
  logic [15:0] pc2;
  logic [15:0] pc3;
  logic [7:0]  op;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic [3:0]  opHi;
  logic [3:0]  opLo;
  logic [7:0]  incAddr;
  logic        cpuTick;

  assign pc1  = q_r.pc + 16'd1;
  assign pc2  = q_r.pc + 16'd2;
  assign pc3  = q_r.pc + 16'd3;
  assign op   = q_r.prog[q_r.pc[PAW-1:0]];
  assign b1   = q_r.prog[pc1[PAW-1:0]];
  assign b2   = q_r.prog[pc2[PAW-1:0]];
  assign opHi = op[7:4];
  assign opLo = op[3:0];

  // cpu clock enable is gated while idle
  assign cpuTick = q_r.tick && (q_r.st != CS_IDLE);

  always_comb begin
    if (op == OP_INC_R) begin
      incAddr = resolve(b1);
    end else if (op == OP_INC_IR) begin
      incAddr = q_r.regs[resolve(b1)];
    end else begin
      incAddr = workAddr(opHi);
    end
  end

  assign ex.incIn   = q_r.regs[incAddr];
  assign ex.flagsIn = q_r.flags;
  assign ex.cc      = opHi;
  assign ex.pcNext  = pc2;
  assign ex.disp    = b1;

  logic [3:0]  cyc;
  logic [31:0] rdVal;
  logic [31:0] wd;

  always_comb begin
    q_nxt = q_r;
    cyc   = CYC_SHORT;
    rdVal = 32'h0000_0000;
    wd    = 32'h0000_0000;

    // first stage feeds only the second
    q_nxt.irqSync = {q_r.irqSync[0], irq};

    // divider halts with the cpu clock; the system clock keeps running
    q_nxt.tick = 1'b0;
    if (q_r.st != CS_IDLE) begin
      if (q_r.divCnt == DIV_LAST) begin
        q_nxt.divCnt = 8'h00;
        q_nxt.tick   = 1'b1;
      end else begin
        q_nxt.divCnt = q_r.divCnt + 8'h01;
      end
    end

    case (q_r.st)
      CS_STOP: begin
        if (q_r.run) begin
          q_nxt.st     = CS_FETCH;
          q_nxt.halted = 1'b0;
        end
      end
      CS_FETCH: begin
        if (cpuTick) begin
          q_nxt.st = CS_WAIT;
          q_nxt.pc = pc1;
          if (q_r.irqSync[1] && q_r.ie) begin
            q_nxt.regs[8'(q_r.sp - 8'd1)] = q_r.pc[7:0];
            q_nxt.regs[8'(q_r.sp - 8'd2)] = q_r.pc[15:8];
            q_nxt.regs[8'(q_r.sp - 8'd3)] = q_r.flags;
            q_nxt.sp = 8'(q_r.sp - 8'd3);
            q_nxt.ie = 1'b0;
            q_nxt.pc = q_r.ivec;
            cyc      = CYC_INT;
          end else begin
            case (op)
              OP_NOP: begin
                cyc = CYC_SHORT;
              end
              OP_IDLE: begin
                q_nxt.idle = 1'b1;
              end
              OP_INTERRUPT_RETURN_OP: begin
                q_nxt.flags = q_r.regs[q_r.sp];
                q_nxt.pc    = {q_r.regs[8'(q_r.sp + 8'd1)],
                               q_r.regs[8'(q_r.sp + 8'd2)]};
                q_nxt.sp    = 8'(q_r.sp + 8'd3);
                q_nxt.ie    = 1'b1;
                cyc         = CYC_INTERRUPT_RETURN_OP;
              end
              OP_INC_R, OP_INC_IR: begin
                q_nxt.regs[incAddr] = ex.incOut;
                q_nxt.flags         = ex.incFlags;
                q_nxt.pc            = pc2;
              end
              OP_JP_IRR: begin
                // two-byte absolute form never tests a condition
                q_nxt.pc = {q_r.regs[resolve(b1)],
                            q_r.regs[8'(resolve(b1) + 8'd1)]};
                cyc      = CYC_JP;
              end
              OP_LD_RIR: begin
                q_nxt.regs[workAddr(b1[7:4])] =
                  q_r.regs[q_r.regs[workAddr(b1[3:0])]];
                q_nxt.pc = pc2;
              end
              OP_LD_IRR: begin
                q_nxt.regs[q_r.regs[workAddr(b1[7:4])]] =
                  q_r.regs[workAddr(b1[3:0])];
                q_nxt.pc = pc2;
              end
              OP_LD_RR: begin
                q_nxt.regs[resolve(b2)] = q_r.regs[resolve(b1)];
                q_nxt.pc = pc3;
                cyc      = CYC_LONG;
              end
              OP_LD_RIRL: begin
                q_nxt.regs[resolve(b2)] = q_r.regs[q_r.regs[resolve(b1)]];
                q_nxt.pc = pc3;
                cyc      = CYC_LONG;
              end
              OP_LD_RIM: begin
                q_nxt.regs[resolve(b1)] = b2;
                q_nxt.pc = pc3;
                cyc      = CYC_LONG;
              end
              OP_LD_IRIM: begin
                q_nxt.regs[q_r.regs[resolve(b1)]] = b2;
                q_nxt.pc = pc3;
                cyc      = CYC_LONG;
              end
              OP_LD_IRRL: begin
                q_nxt.regs[q_r.regs[resolve(b2)]] = q_r.regs[resolve(b1)];
                q_nxt.pc = pc3;
                cyc      = CYC_LONG;
              end
              default: begin
                case (opLo)
                  NIB_INC: begin
                    q_nxt.regs[incAddr] = ex.incOut;
                    q_nxt.flags         = ex.incFlags;
                  end
                  NIB_JP: begin
                    // three-byte absolute form is the conditional one
                    q_nxt.pc = ex.condTrue ? {b1, b2} : pc3;
                    cyc      = CYC_JP;
                  end
                  NIB_JR: begin
                    q_nxt.pc = ex.condTrue ? ex.relTarget : pc2;
                    cyc      = CYC_JR;
                  end
                  NIB_LDIM: begin
                    q_nxt.regs[workAddr(opHi)] = b1;
                    q_nxt.pc = pc2;
                  end
                  NIB_LDRW: begin
                    q_nxt.regs[workAddr(opHi)] = q_r.regs[resolve(b1)];
                    q_nxt.pc = pc2;
                  end
                  NIB_LDWR: begin
                    q_nxt.regs[resolve(b1)] = q_r.regs[workAddr(opHi)];
                    q_nxt.pc = pc2;
                  end
                  default: begin
                    // unknown opcode parks the core until software restarts it
                    q_nxt.halted = 1'b1;
                    q_nxt.st     = CS_HALT;
                    q_nxt.pc     = q_r.pc;
                  end
                endcase
              end
            endcase
          end
          q_nxt.waitCnt = 4'(cyc - 4'd2);
        end
      end
      CS_WAIT: begin
        if (cpuTick) begin
          if (q_r.waitCnt == 4'h0) begin
            q_nxt.st = q_r.idle ? CS_IDLE : CS_FETCH;
          end else begin
            q_nxt.waitCnt = q_r.waitCnt - 4'h1;
          end
        end
      end
      CS_IDLE: begin
        // pc already points past the idle opcode, so fetch resumes there
        if (q_r.irqSync[1]) begin
          q_nxt.idle = 1'b0;
          q_nxt.st   = CS_FETCH;
        end
      end
      CS_HALT: begin
        q_nxt.st = CS_HALT;
      end
      default: begin
        q_nxt.st = CS_STOP;
      end
    endcase

    if (!q_r.run) begin
      q_nxt.st   = CS_STOP;
      q_nxt.idle = 1'b0;
    end

    // avalon read mux
    case (avs_address)
      OFS_CTRL:   rdVal = {30'h0, q_r.ie, q_r.run};
      OFS_STATUS: rdVal = {8'h00, q_r.sp, q_r.flags, 5'h00, q_r.ie, q_r.halted, q_r.idle};
      OFS_PC:     rdVal = {16'h0000, q_r.pc};
      OFS_PADDR:  rdVal = {16'h0000, q_r.paddr};
      OFS_PDATA:  rdVal = {24'h000000, q_r.prog[q_r.paddr[PAW-1:0]]};
      OFS_RADDR:  rdVal = {24'h000000, q_r.raddr};
      OFS_RDATA:  rdVal = {24'h000000, q_r.regs[q_r.raddr]};
      OFS_IVEC:   rdVal = {16'h0000, q_r.ivec};
      OFS_SP:     rdVal = {24'h000000, q_r.sp};
      default:    rdVal = 32'h0000_0000;
    endcase

    // one wait state: waitrequest drops the cycle after a request appears
    q_nxt.waitReq = 1'b1;
    if ((avs_read || avs_write) && q_r.waitReq) begin
      q_nxt.waitReq = 1'b0;
      q_nxt.rdata   = avs_read ? rdVal : q_r.rdata; // writes leave readdata alone
    end

    if (avs_write && !q_r.waitReq) begin
      wd = merge(rdVal, avs_writedata, avs_byteenable);
      case (avs_address)
        OFS_CTRL: begin
          q_nxt.run = wd[CTRL_RUN];
          q_nxt.ie  = wd[CTRL_IE];
        end
        OFS_PC: begin
          if (q_r.st == CS_STOP) begin
            q_nxt.pc = wd[15:0];
          end
        end
        OFS_PADDR: q_nxt.paddr = wd[15:0];
        OFS_PDATA: begin
          q_nxt.prog[q_r.paddr[PAW-1:0]] = wd[7:0];
          q_nxt.paddr = q_r.paddr + 16'd1;
        end
        OFS_RADDR: q_nxt.raddr = wd[7:0];
        OFS_RDATA: begin
          q_nxt.regs[q_r.raddr] = wd[7:0];
          q_nxt.raddr = q_r.raddr + 8'd1;
        end
        OFS_IVEC:  q_nxt.ivec = wd[15:0];
        OFS_SP:    q_nxt.sp = wd[7:0];
        default: begin
          q_nxt.run = q_r.run;
        end
      endcase
    end
  end

  // external reset also ends idle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q_r         <= '0;
      q_r.sp      <= SP_RST;
      q_r.ivec    <= IVEC_RST;
      q_r.st      <= CS_STOP;
      q_r.waitReq <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign avs_readdata    = q_r.rdata;
  assign avs_waitrequest = q_r.waitReq;
  assign cpuIdle         = q_r.idle;
  assign cpuHalted       = q_r.halted;

endmodule : cij_exec_core

// ===== cij_pkg.sv
// constants shared by the idle/increment/jump/load execution core
package cij_pkg;

  // avalon register byte offsets
  localparam logic [5:0]  OFS_CTRL   = 6'h00;
  localparam logic [5:0]  OFS_STATUS = 6'h04;
  localparam logic [5:0]  OFS_PC     = 6'h08;
  localparam logic [5:0]  OFS_PADDR  = 6'h0c;
  localparam logic [5:0]  OFS_PDATA  = 6'h10;
  localparam logic [5:0]  OFS_RADDR  = 6'h14;
  localparam logic [5:0]  OFS_RDATA  = 6'h18;
  localparam logic [5:0]  OFS_IVEC   = 6'h1c;
  localparam logic [5:0]  OFS_SP     = 6'h20;

  // field positions
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_IE   = 1;
  localparam int FL_C      = 7;
  localparam int FL_Z      = 6;
  localparam int FL_S      = 5;
  localparam int FL_V      = 4;

  // reset values and working register base
  localparam logic [7:0]  SP_RST     = 8'hff;
  localparam logic [15:0] IVEC_RST   = 16'h0100;
  localparam logic [7:0]  WORK_BASE  = 8'hc0;

  // full opcodes
  localparam logic [7:0]  OP_IDLE    = 8'h6f;
  localparam logic [7:0]  OP_INTERRUPT_RETURN_OP    = 8'hbf;
  localparam logic [7:0]  OP_NOP     = 8'hff;
  localparam logic [7:0]  OP_INC_R   = 8'h20;
  localparam logic [7:0]  OP_INC_IR  = 8'h21;
  localparam logic [7:0]  OP_JP_IRR  = 8'h30;
  localparam logic [7:0]  OP_LD_RIR  = 8'hc7;
  localparam logic [7:0]  OP_LD_IRR  = 8'hd7;
  localparam logic [7:0]  OP_LD_RR   = 8'he4;
  localparam logic [7:0]  OP_LD_RIRL = 8'he5;
  localparam logic [7:0]  OP_LD_RIM  = 8'he6;
  localparam logic [7:0]  OP_LD_IRIM = 8'hd6;
  localparam logic [7:0]  OP_LD_IRRL = 8'hf5;

  // low-nibble opcodes of the register- or condition-in-upper-nibble forms, and the working register nibble
  localparam logic [3:0]  NIB_INC    = 4'he;
  localparam logic [3:0]  NIB_JP     = 4'hd;
  localparam logic [3:0]  NIB_JR     = 4'hb;
  localparam logic [3:0]  NIB_LDIM   = 4'hc;
  localparam logic [3:0]  NIB_LDRW   = 4'h8;
  localparam logic [3:0]  NIB_LDWR   = 4'h9;
  localparam logic [3:0]  NIB_WORK   = 4'he;

  // condition codes
  localparam logic [3:0]  CC_F   = 4'h0;
  localparam logic [3:0]  CC_LT  = 4'h1;
  localparam logic [3:0]  CC_LE  = 4'h2;
  localparam logic [3:0]  CC_ULE = 4'h3;
  localparam logic [3:0]  CC_OV  = 4'h4;
  localparam logic [3:0]  CC_MI  = 4'h5;
  localparam logic [3:0]  CC_Z   = 4'h6;
  localparam logic [3:0]  CC_C   = 4'h7;
  localparam logic [3:0]  CC_T   = 4'h8;
  localparam logic [3:0]  CC_GE  = 4'h9;
  localparam logic [3:0]  CC_GT  = 4'ha;
  localparam logic [3:0]  CC_UGT = 4'hb;
  localparam logic [3:0]  CC_NOV = 4'hc;
  localparam logic [3:0]  CC_PL  = 4'hd;
  localparam logic [3:0]  CC_NZ  = 4'he;
  localparam logic [3:0]  CC_NC  = 4'hf;

  // cpu cycles per instruction
  localparam logic [3:0]  CYC_SHORT  = 4'h4;
  localparam logic [3:0]  CYC_LONG   = 4'h6;
  localparam logic [3:0]  CYC_JR     = 4'h6;
  localparam logic [3:0]  CYC_JP     = 4'h8;
  localparam logic [3:0]  CYC_INTERRUPT_RETURN_OP   = 4'ha;
  localparam logic [3:0]  CYC_INT    = 4'hc;

  typedef enum logic [2:0] {
    CS_STOP  = 3'b000,
    CS_FETCH = 3'b001,
    CS_WAIT  = 3'b011,
    CS_IDLE  = 3'b010,
    CS_HALT  = 3'b110
  } cij_state_e;

endpackage : cij_pkg

// ===== cij_exec_if.sv
// operands and results passed between the core and its arithmetic units
`timescale 1ns/1ns
interface cij_exec_if;
  logic [7:0]  incIn;
  logic [7:0]  incOut;
  logic [7:0]  flagsIn;
  logic [7:0]  incFlags;
  logic [3:0]  cc;
  logic        condTrue;
  logic [15:0] pcNext;
  logic [7:0]  disp;
  logic [15:0] relTarget;

  modport core (output incIn, flagsIn, cc, pcNext, disp,
                input  incOut, incFlags, condTrue, relTarget);
  modport inc  (input  incIn, flagsIn, output incOut, incFlags);
  modport br   (input  flagsIn, cc, pcNext, disp, output condTrue, relTarget);
endinterface : cij_exec_if

// ===== cij_inc_unit.sv
// increment with flag update
`timescale 1ns/1ns
module cij_inc_unit import cij_pkg::*; (
  // operands
  cij_exec_if.inc ex
);
  always_comb begin
    ex.incOut          = ex.incIn + 8'h01;
    ex.incFlags        = ex.flagsIn;
    ex.incFlags[FL_Z]  = (ex.incOut == 8'h00);
    ex.incFlags[FL_S]  = ex.incOut[7];
    ex.incFlags[FL_V]  = (ex.incIn == 8'h7f);
  end
endmodule : cij_inc_unit

// ===== cij_branch_unit.sv
// condition evaluation and relative target
`timescale 1ns/1ns
module cij_branch_unit import cij_pkg::*; (
  // operands
  cij_exec_if.br ex
);
  logic c;
  logic z;
  logic s;
  logic v;

  assign c = ex.flagsIn[FL_C];
  assign z = ex.flagsIn[FL_Z];
  assign s = ex.flagsIn[FL_S];
  assign v = ex.flagsIn[FL_V];

  // displacement is sign extended and added to the address after the jump
  assign ex.relTarget = ex.pcNext + {{8{ex.disp[7]}}, ex.disp};

  always_comb begin
    case (ex.cc)
      CC_F:    ex.condTrue = 1'b0;
      CC_LT:   ex.condTrue = s ^ v;
      CC_LE:   ex.condTrue = z | (s ^ v);
      CC_ULE:  ex.condTrue = c | z;
      CC_OV:   ex.condTrue = v;
      CC_MI:   ex.condTrue = s;
      CC_Z:    ex.condTrue = z;
      CC_C:    ex.condTrue = c;
      CC_T:    ex.condTrue = 1'b1;
      CC_GE:   ex.condTrue = ~(s ^ v);
      CC_GT:   ex.condTrue = ~(z | (s ^ v));
      CC_UGT:  ex.condTrue = ~(c | z);
      CC_NOV:  ex.condTrue = ~v;
      CC_PL:   ex.condTrue = ~s;
      CC_NZ:   ex.condTrue = ~z;
      CC_NC:   ex.condTrue = ~c;
      default: ex.condTrue = 1'b0;
    endcase
  end
endmodule : cij_branch_unit

// ===== cij_exec_assertions.sv
// port-level checker for the execution core
`timescale 1ns/1ns
module cij_exec_assertions (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // core
  input wire logic        irq,
  input wire logic        cpuIdle,
  input wire logic        cpuHalted
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
  property p_handshake; s_req |=> s_ack; endproperty
  property p_quiet; !(avs_read || avs_write) |=> avs_waitrequest; endproperty
  property p_rdata; $changed(avs_readdata) |-> $past(avs_read); endproperty
  // irq passes two sync flops, so three quiet samples prove no wake is in flight
  property p_idle_hold;
    cpuIdle && !irq && !$past(irq) && !$past(irq, 2) && !avs_write |=> cpuIdle;
  endproperty
  property p_wake; cpuIdle && irq |-> ##[1:6] !cpuIdle; endproperty
  property p_rst_exit; $fell(rst) |-> !cpuIdle && !cpuHalted; endproperty
  property p_excl; !(cpuIdle && cpuHalted); endproperty
  property p_halt_hold; cpuHalted && !avs_write |=> cpuHalted; endproperty
  a_handshake: assert property (p_handshake) else $error("bus answer not in one cycle");
  a_quiet: assert property (p_quiet) else $error("waitrequest low without request");
  a_rdata: assert property (p_rdata) else $error("readdata moved without read");
  a_idle_hold: assert property (p_idle_hold) else $error("idle left without wake");
  a_wake: assert property (p_wake) else $error("irq did not end idle");
  a_rst_exit: assert property (p_rst_exit) else $error("idle survived reset");
  a_excl: assert property (p_excl) else $error("idle and halted together");
  a_halt_hold: assert property (p_halt_hold) else $error("halt cleared by itself");
endmodule : cij_exec_assertions

// ===== testbench.sv
// self-checking bench for the execution core
`timescale 1ns/1ns
module testbench;
  import cij_pkg::*;
  logic        clk_sys;
  logic        rst;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        cpuIdle;
  logic        cpuHalted;
  int          miscompares;
  int          checked;
  int          seed;
  logic [7:0]  immVal;
  logic [15:0] e;
  logic [15:0] expQ [$];
  logic [7:0]  prog [0:43];
  logic [7:0]  regInit [0:5] = '{8'h7f, 8'hff, 8'h00, 8'h00, 8'h00, 8'h20};

  cij_exec_core uut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .cpuIdle(cpuIdle),
    .cpuHalted(cpuHalted));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic hang;
    miscompares++;
    finish_test();
  endtask : hang

  task automatic check(input logic [5:0] ofs, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED offset %h expected %h seen %h", ofs, exp, seen);
    end
  endtask : check

  // request held until waitrequest is sampled low, released after that edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      hang();
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [1:0] lane, input logic [7:0] exp);
    expQ.push_back({a, lane, exp});
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic rdReg(input logic [7:0] a, input logic [7:0] exp);
    wr(OFS_RADDR, {24'h0, a});
    rd(OFS_RDATA, 2'h0, exp);
  endtask : rdReg

  task automatic waitIdle;
    int n;
    for (n = 0; n < 2000 && cpuIdle !== 1'b1; n++)
      @(posedge clk_sys);
    if (n >= 2000)
      hang();
  endtask : waitIdle

  // irq is a level, so it stays up until the core is seen awake
  task automatic wake;
    int n;
    irq <= 1'b1;
    for (n = 0; n < 20 && cpuIdle !== 1'b0; n++)
      @(posedge clk_sys);
    if (n >= 20)
      hang();
    irq <= 1'b0;
  endtask : wake

  always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && expQ.size() > 0) begin
      e = expQ.pop_front();
      check(e[15:10], avs_readdata[e[9:8]*8 +: 8], e[7:0]);
    end
  end

  initial begin
    rst = 1'b1;
    avs_address = 6'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    irq = 1'b0;
    seed = 32'hb4a9aa70;
    immVal = 8'($random(seed));
    for (int i = 0; i < 44; i++)
      prog[i] = 8'h2e;
    {prog[0], prog[1], prog[2], prog[3], prog[4], prog[5]} = {8'h0e, OP_IDLE, 8'h1e, OP_IDLE,
      8'h8b, 8'h02};
    {prog[8], prog[9], prog[10], prog[11], prog[12]} = {8'h0b, 8'h7f, 8'h8d, 8'h00, 8'h10};
    {prog[16], prog[17], prog[32], prog[33]} = {OP_JP_IRR, 8'hc4, 8'h3c, immVal};
    {prog[34], prog[35], prog[36], prog[37], prog[38]} = {OP_LD_RR, 8'hc3, 8'hc7, 8'h8b, 8'h02};
    {prog[39], prog[40], prog[41], prog[42]} = {8'h4e, OP_IDLE, 8'h8b, 8'hfc};
    prog[43] = OP_INTERRUPT_RETURN_OP;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    wr(OFS_PADDR, 32'h0);
    for (int i = 0; i < 44; i++)
      wr(OFS_PDATA, {24'h0, prog[i]});
    rd(OFS_PADDR, 2'h0, 8'h2c);
    wr(OFS_RADDR, 32'hc0);
    for (int i = 0; i < 6; i++)
      wr(OFS_RDATA, {24'h0, regInit[i]});
    wr(OFS_CTRL, 32'h1);
    waitIdle();
    rd(OFS_STATUS, 2'h0, 8'h01);
    rdReg(8'hc0, 8'h80);
    rd(OFS_STATUS, 2'h1, 8'h30);
    wake();
    waitIdle();
    rdReg(8'hc1, 8'h00);
    rd(OFS_STATUS, 2'h1, 8'h40);
    wake();
    waitIdle();
    rdReg(8'hc2, 8'h00);
    rdReg(8'hc3, immVal);
    rdReg(8'hc7, immVal);
    rdReg(8'hc4, 8'h01);
    rd(OFS_STATUS, 2'h1, 8'h00);
    rd(OFS_STATUS, 2'h0, 8'h01);
    rd(6'h24, 2'h0, 8'h00);
    // handler at 2b is a lone return; wake with interrupts enabled
    wr(OFS_IVEC, 32'h0000_002b);
    wr(OFS_CTRL, 32'h0000_0003);
    wake();
    waitIdle();
    rdReg(8'hc4, 8'h02);
    rdReg(8'hfe, 8'h29);
    rd(OFS_SP, 2'h0, 8'hff);
    rd(OFS_STATUS, 2'h0, 8'h05);
    rd(OFS_STATUS, 2'h1, 8'h00);
    // reset while idle must leave the core awake and stopped
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFS_STATUS, 2'h0, 8'h00);
    finish_test();
  end
endmodule : testbench

bind cij_exec_core cij_exec_assertions chk (.clk_sys(clk_sys), .rst(rst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .cpuIdle(cpuIdle),
  .cpuHalted(cpuHalted));
